// *** inc/crsc_pkg.sv ***
/*
 * Shared constants for the coefficient buffer swap control block:
 * register page and address map, field positions and reset values.
 * Assumes the serial control port presents raw page/address values with read/write strobes.
 */
`default_nettype none

package crsc_pkg;

  // ****************************************************************
  // Register map (page, address within page)
  // ****************************************************************
  localparam logic [7:0] PAGE_SWAP_CTRL   = 8'h2C;
  localparam logic [6:0] ADDR_SWAP_CTRL   = 7'h01;
  localparam logic [7:0] PAGE_CLK_ROUTE   = 8'hFD;
  localparam logic [6:0] ADDR_CLK_ROUTE_1 = 7'h3F;
  localparam logic [6:0] ADDR_CLK_ROUTE_2 = 7'h40;

  // ****************************************************************
  // Field positions in coeff_buffer_swap_ctrl
  // ****************************************************************
  localparam int unsigned BIT_SWAP_REQ = 0;
  localparam int unsigned BIT_ACTIVE   = 1;
  localparam int unsigned BIT_ADAPTIVE = 2;
  localparam int unsigned BIT_MONITOR  = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_CLK_ROUTE_1 = 8'h00;
  localparam logic [7:0] RST_CLK_ROUTE_2 = 8'h00;
  localparam logic       RST_ADAPTIVE    = 1'b0;
  localparam logic       RST_ACTIVE      = 1'b0;
  localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

  // Buffer encoding used by the indicator and the monitor
  localparam logic BUF_A = 1'b0;
  localparam logic BUF_B = 1'b1;

  // Swap sequencer states
  typedef enum logic [1:0] {
    CRSC_IDLE = 2'b01,
    CRSC_WAIT = 2'b10
  } crsc_swap_e;

endpackage

`default_nettype wire

// *** rtl/crsc_port_route.sv ***
/*
 * Serial-port access routing to coefficient buffers A and B.
 * Assumes all inputs are on clk_sys_i; outputs are registered.
 */
`default_nettype none

module crsc_port_route (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic adaptive_i,
  input  wire logic dsp_run_i,
  input  wire logic active_i,
  output logic      port_buf_a_en_o,
  output logic      port_buf_b_en_o
);

  logic a_next;
  logic b_next;

  always_comb begin
    a_next = 1'b0;
    b_next = 1'b0;
    if (adaptive_i) begin
      if (!dsp_run_i) begin
        a_next = 1'b1;
      end else begin
        a_next = (active_i == crsc_pkg::BUF_B);
        b_next = (active_i == crsc_pkg::BUF_A);
      end
    end else begin
      a_next = !dsp_run_i;
      b_next = !dsp_run_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_buf_a_en_o <= 1'b0;
      port_buf_b_en_o <= 1'b0;
    end else if (ce_i) begin
      port_buf_a_en_o <= a_next;
      port_buf_b_en_o <= b_next;
    end
  end

endmodule

`default_nettype wire

// *** rtl/crsc_ctrl.sv ***
/*
 * Coefficient buffer swap control and clock-routing register bank.
 * Holds the swap request, active-buffer state, adaptive mode enable
 * and the two clock-routing registers; routes serial-port access.
 * Assumes the serial control port delivers one-cycle read/write
 * strobes with page and address on clk_sys_i, and that the processor
 * core gives a one-cycle frame_start_i pulse on the same clock.
 */
// Notes on behaviour
// - Read-only status shows which coefficient buffer is active.
// - Adaptive and running: the inactive buffer is the update buffer, reachable from the serial port.
// - Active status reads 0 for buffer A, 1 for buffer B.
// - Writing 1 to bit 0 requests exchange of active and update roles.
// - Request bit clears itself when exchange finishes; reads 1 while pending.
// - Adaptive and stopped: only A reachable; running: port gets the other.
// - Non-adaptive: both reachable when stopped, neither while running.
`default_nettype none

module crsc_ctrl (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] reg_page_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       dsp_run_i,
  input  wire logic       frame_start_i,
  input  wire logic       dsp_buf_use_i,
  output logic      [7:0] reg_rdata_o,
  output logic            active_buf_o,
  output logic            adaptive_o,
  output logic            swap_done_o,
  output logic            port_buf_a_en_o,
  output logic            port_buf_b_en_o,
  output logic      [7:0] clk_route_one_o,
  output logic      [7:0] clk_route_two_o
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] pg,
                               input logic [6:0] ad,
                               input logic [7:0] tp,
                               input logic [6:0] ta);
    hit = (pg == tp) && (ad == ta);
  endfunction

  logic sel_swap;
  logic sel_rt1;
  logic sel_rt2;

  assign sel_swap = hit(reg_page_i, reg_addr_i, crsc_pkg::PAGE_SWAP_CTRL,
                        crsc_pkg::ADDR_SWAP_CTRL);
  assign sel_rt1  = hit(reg_page_i, reg_addr_i, crsc_pkg::PAGE_CLK_ROUTE,
                        crsc_pkg::ADDR_CLK_ROUTE_1);
  assign sel_rt2  = hit(reg_page_i, reg_addr_i, crsc_pkg::PAGE_CLK_ROUTE,
                        crsc_pkg::ADDR_CLK_ROUTE_2);

  // ****************************************************************
  // State
  // ****************************************************************
  crsc_pkg::crsc_swap_e state_reg;
  crsc_pkg::crsc_swap_e state_next;
  logic                 swap_req_reg;
  logic                 active_reg;
  logic                 adaptive_reg;
  logic                 monitor_reg;
  logic                 swap_fire;
  logic                 req_write;

  assign req_write = reg_wr_i && sel_swap && reg_wdata_i[crsc_pkg::BIT_SWAP_REQ];

  // ****************************************************************
  // Swap sequencer
  // ****************************************************************
  // A stopped processor has no frames, so the swap is taken at once;
  // a running one waits for the boundary to keep every frame whole.
  always_comb begin
    state_next = state_reg;
    swap_fire  = 1'b0;
    case (state_reg)
      crsc_pkg::CRSC_IDLE: begin
        if (swap_req_reg) begin
          state_next = crsc_pkg::CRSC_WAIT;
        end
      end
      crsc_pkg::CRSC_WAIT: begin
        if (!dsp_run_i || frame_start_i) begin
          swap_fire  = 1'b1;
          state_next = crsc_pkg::CRSC_IDLE;
        end
      end
      default: begin
        state_next = crsc_pkg::CRSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= crsc_pkg::CRSC_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Request bit: a new write of 1 wins over the self-clear
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      swap_req_reg <= 1'b0;
    end else if (ce_i) begin
      if (req_write) begin
        swap_req_reg <= 1'b1;
      end else if (swap_fire) begin
        swap_req_reg <= 1'b0;
      end
    end
  end

  // Active buffer flips in one edge, so the core sees one value per frame
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_reg <= crsc_pkg::RST_ACTIVE;
    end else if (ce_i && swap_fire) begin
      active_reg <= ~active_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      swap_done_o <= 1'b0;
    end else if (ce_i) begin
      swap_done_o <= swap_fire;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      adaptive_reg <= crsc_pkg::RST_ADAPTIVE;
    end else if (ce_i && reg_wr_i && sel_swap) begin
      adaptive_reg <= reg_wdata_i[crsc_pkg::BIT_ADAPTIVE];
    end
  end

  // Routing value is stored as written; 0x11 is expected for pin routing
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_route_one_o <= crsc_pkg::RST_CLK_ROUTE_1;
      clk_route_two_o <= crsc_pkg::RST_CLK_ROUTE_2;
    end else if (ce_i && reg_wr_i) begin
      if (sel_rt1) begin
        clk_route_one_o <= reg_wdata_i;
      end
      if (sel_rt2) begin
        clk_route_two_o <= reg_wdata_i;
      end
    end
  end

  // Buffer actually in use by the core, for the monitor bit
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      monitor_reg <= crsc_pkg::BUF_A;
    end else if (ce_i) begin
      monitor_reg <= dsp_buf_use_i;
    end
  end

  // ****************************************************************
  // Outputs to the core
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_buf_o <= crsc_pkg::RST_ACTIVE;
      adaptive_o   <= crsc_pkg::RST_ADAPTIVE;
    end else if (ce_i) begin
      active_buf_o <= active_reg;
      adaptive_o   <= adaptive_reg;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] swap_view;

  always_comb begin
    swap_view                          = 8'h00;
    swap_view[crsc_pkg::BIT_SWAP_REQ]  = swap_req_reg;
    swap_view[crsc_pkg::BIT_ACTIVE]    = active_reg;
    swap_view[crsc_pkg::BIT_ADAPTIVE]  = adaptive_reg;
    swap_view[crsc_pkg::BIT_MONITOR]   = monitor_reg;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= crsc_pkg::RDATA_UNMAPPED;
    end else if (ce_i && reg_rd_i) begin
      if (sel_swap) begin
        reg_rdata_o <= swap_view;
      end else if (sel_rt1) begin
        reg_rdata_o <= clk_route_one_o;
      end else if (sel_rt2) begin
        reg_rdata_o <= clk_route_two_o;
      end else begin
        reg_rdata_o <= crsc_pkg::RDATA_UNMAPPED;
      end
    end
  end

  // ****************************************************************
  // Serial-port access routing
  // ****************************************************************
  crsc_port_route u_route (
    .clk_sys_i       (clk_sys_i),
    .sys_rst_i       (sys_rst_i),
    .ce_i            (ce_i),
    .adaptive_i      (adaptive_reg),
    .dsp_run_i       (dsp_run_i),
    .active_i        (active_reg),
    .port_buf_a_en_o (port_buf_a_en_o),
    .port_buf_b_en_o (port_buf_b_en_o)
  );

endmodule

`default_nettype wire

// *** dv/crsc_ctrl_sva.sv ***
/* Port assertions for crsc_ctrl.
   Assumes a single clk_sys_i domain; bound into every crsc_ctrl. */
`default_nettype none
module crsc_ctrl_sva (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       ce_i,
  input wire logic [7:0] reg_page_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       dsp_run_i,
  input wire logic       frame_start_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       active_buf_o,
  input wire logic       adaptive_o,
  input wire logic       swap_done_o,
  input wire logic       port_buf_a_en_o,
  input wire logic       port_buf_b_en_o,
  input wire logic [7:0] clk_route_two_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire pg_sw = reg_page_i == crsc_pkg::PAGE_SWAP_CTRL && reg_addr_i == crsc_pkg::ADDR_SWAP_CTRL;
  wire pg_r2 = reg_page_i == crsc_pkg::PAGE_CLK_ROUTE && reg_addr_i == crsc_pkg::ADDR_CLK_ROUTE_2;
  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence s_swap_req; ce_i && reg_wr_i && pg_sw && reg_wdata_i[0]; endsequence
  sequence s_plain_stop; (ce_i && !adaptive_o && !dsp_run_i)[*2]; endsequence
  sequence s_plain_run; (ce_i && !adaptive_o && dsp_run_i)[*2]; endsequence
  sequence s_adapt_stop; (ce_i && adaptive_o && !dsp_run_i)[*2]; endsequence
  // Three cycles: indicator trails the internal role by one
  sequence s_adapt_run;
    (ce_i && adaptive_o && dsp_run_i && $stable(active_buf_o))[*3];
  endsequence
  // Done holds while the enable is low, so only an enabled cycle must drop it
  chk_done_pulse: assert property (
    swap_done_o && ce_i |=> !swap_done_o)
    else $error("swap done wider than one cycle");
  chk_stop_swap: assert property (
    s_swap_req ##1 (ce_i && !dsp_run_i)[*2] |=> swap_done_o)
    else $error("stopped swap not done in time");
  chk_frame_edge: assert property (
    swap_done_o && $past(ce_i) |-> $past(frame_start_i) || !$past(dsp_run_i))
    else $error("swap outside frame boundary");
  chk_active_flip: assert property (
    swap_done_o && ce_i |=> $changed(active_buf_o))
    else $error("active buffer did not flip");
  chk_active_cause: assert property (
    $changed(active_buf_o) |-> $past(swap_done_o))
    else $error("active buffer changed without swap");
  chk_route_two: assert property (
    ce_i && reg_wr_i && pg_r2 |=> clk_route_two_o == $past(reg_wdata_i))
    else $error("routing register two not written");
  chk_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_plain_stop: assert property (
    s_plain_stop |-> port_buf_a_en_o && port_buf_b_en_o)
    else $error("stopped plain mode lacks both buffers");
  chk_plain_run: assert property (
    s_plain_run |-> !port_buf_a_en_o && !port_buf_b_en_o)
    else $error("running plain mode grants a buffer");
  chk_adapt_stop: assert property (
    s_adapt_stop |-> port_buf_a_en_o && !port_buf_b_en_o)
    else $error("stopped adaptive mode not buffer A only");
  chk_adapt_run: assert property (
    s_adapt_run |-> port_buf_b_en_o == !active_buf_o && port_buf_a_en_o == active_buf_o)
    else $error("update buffer not the inactive one");
endmodule
bind crsc_ctrl crsc_ctrl_sva crsc_ctrl_sva_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .ce_i(ce_i), .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .dsp_run_i(dsp_run_i),
  .frame_start_i(frame_start_i), .reg_rdata_o(reg_rdata_o), .active_buf_o(active_buf_o),
  .adaptive_o(adaptive_o), .swap_done_o(swap_done_o), .port_buf_a_en_o(port_buf_a_en_o),
  .port_buf_b_en_o(port_buf_b_en_o), .clk_route_two_o(clk_route_two_o));
`default_nettype wire

// *** dv/crsc_dsp_model.sv ***
/* Processor core model: frame pulses while running, buffer in use.
   Assumes clk_sys_i; drives on the falling edge. */
`default_nettype none
module crsc_dsp_model #(parameter int FRAME = 32) (
  input  wire logic clk_sys_i,
  input  wire logic dsp_run_i,
  input  wire logic active_buf_i,
  output var  logic frame_start_o,
  output var  logic dsp_buf_use_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Outputs start unknown until the first falling edge (buffer in use: the second, if running); the model has no reset input
  always @(negedge clk_sys_i) begin
    cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
    frame_start_o <= dsp_run_i && cnt == 0;
    // Core only changes buffer between frames
    if (frame_start_o || !dsp_run_i) dsp_buf_use_o <= active_buf_i;
  end
endmodule
`default_nettype wire

// *** dv/coeff_ram_swap_ctrl_test.sv ***
/* Register-level regression for crsc_ctrl.
   Assumes crsc_pkg, crsc_dsp_model and the bound checker are compiled. */
`default_nettype none
module coeff_ram_swap_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] PS = crsc_pkg::PAGE_SWAP_CTRL;
  localparam logic [7:0] PR = crsc_pkg::PAGE_CLK_ROUTE;
  localparam logic [6:0] AS = crsc_pkg::ADDR_SWAP_CTRL;
  localparam logic [6:0] A1 = crsc_pkg::ADDR_CLK_ROUTE_1;
  localparam logic [6:0] A2 = crsc_pkg::ADDR_CLK_ROUTE_2;
  logic       clk_sys_i, sys_rst_i, ce_i, reg_wr_i, reg_rd_i, dsp_run_i, frame_start_i;
  logic       dsp_buf_use_i, active_buf_o, adaptive_o, swap_done_o, a_en, b_en;
  logic [7:0] reg_page_i, reg_wdata_i, reg_rdata_o, route_one, route_two;
  logic [6:0] reg_addr_i;
  int         bad_count = 0;
  int         total_checks = 0;
  crsc_ctrl crsc_ctrl_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .dsp_run_i(dsp_run_i), .frame_start_i(frame_start_i),
    .dsp_buf_use_i(dsp_buf_use_i), .reg_rdata_o(reg_rdata_o), .active_buf_o(active_buf_o),
    .adaptive_o(adaptive_o), .swap_done_o(swap_done_o), .port_buf_a_en_o(a_en),
    .port_buf_b_en_o(b_en), .clk_route_one_o(route_one), .clk_route_two_o(route_two));
  crsc_dsp_model crsc_dsp_model_inst (.clk_sys_i(clk_sys_i), .dsp_run_i(dsp_run_i),
    .active_buf_i(active_buf_o), .frame_start_o(frame_start_i), .dsp_buf_use_o(dsp_buf_use_i));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobe dropped for a cycle so no signal is set twice in one step
  task automatic wr(input logic [7:0] p, input logic [6:0] a, input logic [7:0] d);
    {reg_page_i, reg_addr_i, reg_wdata_i, reg_wr_i} = {p, a, d, 1'b1};
    @(negedge clk_sys_i) reg_wr_i = 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] p, input logic [6:0] a, input logic [7:0] e, input string n);
    {reg_page_i, reg_addr_i, reg_rd_i} = {p, a, 1'b1};
    @(negedge clk_sys_i) reg_rd_i = 1'b0;
    chk(n, e, reg_rdata_o);
    @(negedge clk_sys_i);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 100 && swap_done_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk("swap done", 8'h01, swap_done_o);
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************************************
  // Clock, watchdog, tests
  // ****************************************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    complete_run();
  end
  initial begin
    {sys_rst_i, ce_i, reg_wr_i, reg_rd_i, dsp_run_i} = 5'b11000;
    {reg_page_i, reg_addr_i, reg_wdata_i} = '0;
    repeat (16) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    rd(PR, A1, crsc_pkg::RST_CLK_ROUTE_1, "route one");
    rd(PR, A2, crsc_pkg::RST_CLK_ROUTE_2, "route two");
    rd(PS, AS, 8'h00, "swap ctrl");
    $display("test reset done");
    wr(PR, A1, 8'h11);
    wr(PR, A2, 8'h11);
    wr(8'h00, A1, 8'hFF);
    rd(PR, A1, 8'h11, "route one");
    rd(PR, A2, 8'h11, "route two");
    ce_i = 1'b0;
    wr(PR, A2, 8'hEE);
    ce_i = 1'b1;
    chk("route two pins", 8'h11, route_two);
    chk("route one pins", 8'h11, route_one);
    rd(8'h00, A1, crsc_pkg::RDATA_UNMAPPED, "unmapped");
    $display("test routing done");
    chk("plain stopped", 8'h03, {a_en, b_en});
    wr(PS, AS, 8'h03);
    wait_done();
    chk("active", 8'h01, active_buf_o);
    rd(PS, AS, 8'h0A, "swap ctrl");
    wr(PS, AS, 8'h04);
    chk("adaptive out", 8'h01, adaptive_o);
    dsp_run_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk("adaptive run", 8'h02, {a_en, b_en});
    @(posedge frame_start_i);
    @(negedge clk_sys_i);
    wr(PS, AS, 8'h05);
    rd(PS, AS, 8'h0F, "swap pending");
    wait_done();
    chk("active", 8'h00, active_buf_o);
    chk("adaptive run", 8'h01, {a_en, b_en});
    dsp_run_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk("adaptive stopped", 8'h02, {a_en, b_en});
    wr(PS, AS, 8'h00);
    chk("adaptive out", 8'h00, adaptive_o);
    dsp_run_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk("plain run", 8'h00, {a_en, b_en});
    $display("test swap done");
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    rd(PR, A1, crsc_pkg::RST_CLK_ROUTE_1, "route one");
    rd(PS, AS, 8'h00, "swap ctrl");
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
